// [src/dets_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dets_defines.svh"

module dets_top
  import dets_pkg::*;
#(
  parameter int DATA_W = 64
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic warm_rst,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [15:0][15:0] err_count,
  input wire logic [15:0] single_bit_corrected_threshold,
  input wire logic [15:0] uncorrectable_threshold_value,
  input wire logic in_valid,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic in_parity_err,
  output logic out_valid,
  output logic [DATA_W-1:0] out_data,
  output logic out_poison,
  output logic [15:0] flags_out
);

  // -------------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------------
  function automatic logic hits_reg(input logic [7:0] a, input logic [7:0] ofs);
    hits_reg = (a[7:`DETS_DWORD_LSB] == ofs[7:`DETS_DWORD_LSB]);
  endfunction

  function automatic logic over_thr(input dets_count_t cnt, input dets_count_t thr);
    over_thr = (cnt > thr);
  endfunction

  dets_flags_t flags_reg, flags_next;
  dets_flags_t hit;
  dets_flags_t clr;
  logic poison_en_reg, poison_en_next;
  dets_word_t rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic ovalid_reg, ovalid_next;
  logic [DATA_W-1:0] odata_reg, odata_next;
  logic opoison_reg, opoison_next;

  // -------------------------------------------------------------------------
  // Threshold compare per counter
  // -------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_cmp
      // Index bit 2 selects the uncorrectable half of each channel
      localparam bit IS_DED = bit'((gi >> `DETS_DED_SEL_BIT) & 1);
      // Strict greater-than: a count sitting on its threshold is no event
      always_comb
      begin
        if (IS_DED)
          hit[gi] = over_thr(err_count[gi], uncorrectable_threshold_value);
        else
          hit[gi] = over_thr(err_count[gi], single_bit_corrected_threshold);
      end
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb
  begin
    clr = '0;
    if (cfg_wr && hits_reg(cfg_addr, `DETS_FLAGS_OFS))
      clr = cfg_wdata[15:0] & {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
    // A new hit beats a clear in the same cycle so no event is lost
    flags_next = (flags_reg & ~clr) | hit;

    // Ordinary reset drops the enable; the sticky flags ride through it
    poison_en_next = poison_en_reg;
    if (warm_rst)
      poison_en_next = 1'b0;
    else if (cfg_wr && hits_reg(cfg_addr, `DETS_PBCTL_OFS) && cfg_be[`DETS_POISON_LANE])
      poison_en_next = cfg_wdata[`DETS_POISON_BIT];

    // Unmapped offsets, the host link control among them, read as zero
    rvalid_next = cfg_rd;
    rdata_next = '0;
    if (cfg_rd)
    begin
      if (hits_reg(cfg_addr, `DETS_FLAGS_OFS))
        rdata_next = {16'h0000, flags_reg};
      else if (hits_reg(cfg_addr, `DETS_PBCTL_OFS))
      begin
        rdata_next = `DETS_PBCTL_FIXED;
        rdata_next[`DETS_POISON_BIT] = poison_en_reg;
      end
    end

    ovalid_next = in_valid;
    odata_next = in_data;
    opoison_next = in_valid && in_parity_err && poison_en_reg;
  end

  // -------------------------------------------------------------------------
  // Sticky flags: only the power-good reset or a write of one clears them
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flags_reg <= `DETS_FLAGS_RST;
    else
      flags_reg <= flags_next;
  end

  // -------------------------------------------------------------------------
  // Control, read port and data path
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      poison_en_reg <= 1'(`DETS_PBCTL_RST >> `DETS_POISON_BIT);
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
      ovalid_reg <= 1'b0;
      odata_reg <= '0;
      opoison_reg <= 1'b0;
    end
    else
    begin
      poison_en_reg <= poison_en_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      ovalid_reg <= ovalid_next;
      odata_reg <= odata_next;
      opoison_reg <= opoison_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;
  assign out_valid = ovalid_reg;
  assign out_data = odata_reg;
  assign out_poison = opoison_reg;
  assign flags_out = flags_reg;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Internal state is watched so a broken next-state path shows at its source
  flag_ded_map_a: assert property (
    (err_count[5] > uncorrectable_threshold_value) |=> flags_reg[5])
    else $error("ded flag not set");
  flag_on_hit_a: assert property (
    1 |=> ((flags_reg & $past(hit)) == $past(hit)))
    else $error("hit not recorded");
  flag_level_a: assert property (
    (hit == '0 && clr == '0) |=> $stable(flags_reg))
    else $error("flag changed on its own");
  w1c_exact_a: assert property (
    (hit == '0) |=> flags_reg == ($past(flags_reg) & ~$past(clr)))
    else $error("clear not exact");
  zero_write_a: assert property (
    (cfg_wr && cfg_wdata[15:0] == 16'h0000) |=> (($past(flags_reg) & ~flags_reg) == '0))
    else $error("zero write cleared");
  warm_keep_a: assert property (
    (warm_rst && clr == '0) |=> (($past(flags_reg) & ~flags_reg) == '0))
    else $error("warm reset cleared");
  flag_read_a: assert property (
    (cfg_rd && hits_reg(cfg_addr, `DETS_FLAGS_OFS))
    |=> cfg_rvalid && cfg_rdata[15:0] == $past(flags_reg))
    else $error("flag read");
  poison_on_a: assert property (
    (in_valid && in_parity_err && poison_en_reg) |=> out_poison && out_valid)
    else $error("no poison");
  poison_off_a: assert property (
    !poison_en_reg |=> !out_poison)
    else $error("poison while off");
  ctl_read_a: assert property ((cfg_rd && hits_reg(cfg_addr, `DETS_PBCTL_OFS))
    |=> ((cfg_rdata & `DETS_PBCTL_RSVD_MASK) == `DETS_PBCTL_FIXED))
    else $error("ctl reserved bits");
  warm_clear_a: assert property (
    warm_rst |=> !poison_en_reg)
    else $error("warm reset kept enable");
  ctl_keep_a: assert property (
    (!warm_rst && !(cfg_wr && cfg_be[`DETS_POISON_LANE])) |=> $stable(poison_en_reg))
    else $error("enable moved without write");
  poison_write_a: assert property (
    (cfg_wr && hits_reg(cfg_addr, `DETS_PBCTL_OFS) && cfg_be[`DETS_POISON_LANE] && !warm_rst)
    |=> poison_en_reg == $past(cfg_wdata[`DETS_POISON_BIT]))
    else $error("enable write lost");
  unmapped_read_a: assert property (
    (cfg_rd && !hits_reg(cfg_addr, `DETS_FLAGS_OFS) && !hits_reg(cfg_addr, `DETS_PBCTL_OFS))
    |=> cfg_rvalid && cfg_rdata == '0)
    else $error("unmapped read not zero");
  data_pass_a: assert property (
    in_valid |=> out_valid && out_data == $past(in_data))
    else $error("beat not forwarded");

  // -------------------------------------------------------------------------
  // Cover points
  // -------------------------------------------------------------------------
  set_clear_c: cover property (clr != '0 ##1 hit != '0);
  hit_beats_clear_c: cover property ((clr & hit) != '0);
  poison_c: cover property (in_valid && in_parity_err && poison_en_reg);
  warm_c: cover property (warm_rst && flags_reg != '0);
  ctl_write_c: cover property (cfg_wr && hits_reg(cfg_addr, `DETS_PBCTL_OFS));

endmodule

`default_nettype wire

// [src/dets_defines.svh]
`ifndef DETS_DEFINES_SVH
`define DETS_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register map, configuration space byte offsets (dword aligned)
// ---------------------------------------------------------------------------
`define DETS_FLAGS_OFS 8'hDC
`define DETS_PBCTL_OFS 8'hE0
`define DETS_HLCTL_OFS 8'hE4

// ---------------------------------------------------------------------------
// Reset values and field layout
// ---------------------------------------------------------------------------
`define DETS_FLAGS_RST 16'h0000
`define DETS_PBCTL_RST 32'h0020_0000
`define DETS_PBCTL_FIXED 32'h0020_0000
`define DETS_PBCTL_RSVD_MASK 32'hFFFB_FFFF
`define DETS_POISON_BIT 18
`define DETS_POISON_LANE 2
`define DETS_DED_SEL_BIT 2
`define DETS_DWORD_LSB 2

`endif

// [src/dets_pkg.sv]
package dets_pkg;

  typedef logic [15:0] dets_flags_t;
  typedef logic [15:0] dets_count_t;
  typedef logic [31:0] dets_word_t;

endpackage

// [dv/dets_testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end

module testbench;
  import dets_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, warm_rst = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic in_valid = 1'b0, in_parity_err = 1'b0, cfg_rvalid, out_valid, out_poison;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  dets_word_t cfg_wdata = 32'h0, cfg_rdata, rdat;
  logic [15:0][15:0] err_count = '0;
  dets_count_t sthr = 16'h0, dthr = 16'h0;
  logic [63:0] in_data = 64'h0, out_data;
  dets_flags_t flags_out, exp_flags, m;
  int n_mismatch = 0, checks_done = 0;

  always #12.5 clk = ~clk;

  dets_top #(.DATA_W(64)) dets_top_inst (.clk(clk), .arst_n(arst_n), .warm_rst(warm_rst),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .err_count(err_count), .single_bit_corrected_threshold(sthr),
    .uncorrectable_threshold_value(dthr), .in_valid(in_valid), .in_data(in_data),
    .in_parity_err(in_parity_err), .out_valid(out_valid), .out_data(out_data),
    .out_poison(out_poison), .flags_out(flags_out));

  // ---------------------------------------------------------------------------
  // Bus tasks, entered and left at a falling edge, one idle edge after each strobe
  // ---------------------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [3:0] be, input dets_word_t d);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
  endtask

  task rd(input logic [7:0] a, output dets_word_t d);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge clk);
    cfg_rd = 1'b0;
    d = cfg_rvalid ? cfg_rdata : ~cfg_rdata;
    @(negedge clk);
  endtask

  task beat(input logic perr, input logic exp_p);
    logic [63:0] d;
    d = {$urandom, $urandom};
    in_data = d;
    in_parity_err = perr;
    in_valid = 1'b1;
    @(negedge clk);
    in_valid = 1'b0;
    `CHK(out_valid, 1'b1)
    `CHK(out_data, d)
    `CHK(out_poison, exp_p)
    @(negedge clk);
    `CHK(out_valid, 1'b0)
    `CHK(out_poison, 1'b0)
  endtask

  // Strict compare: a count equal to its threshold is no hit
  function automatic dets_flags_t hits();
    for (int i = 0; i < 16; i++)
      hits[i] = err_count[i] > (i[2] ? dthr : sthr);
  endfunction

  task wrap_up;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    void'($urandom(1758));
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    rd(8'hE0, rdat);
    `CHK(rdat, 32'h0020_0000)
    rd(8'hDC, rdat);
    `CHK(rdat, 32'h0000_0000)
    wr(8'hE0, 4'hF, 32'hFFFF_FFFF);
    rd(8'hE0, rdat);
    `CHK(rdat, 32'h0024_0000)
    beat(1'b1, 1'b1);
    beat(1'b0, 1'b0);
    warm_rst = 1'b1;
    @(negedge clk);
    warm_rst = 1'b0;
    rd(8'hE0, rdat);
    `CHK(rdat, 32'h0020_0000)
    beat(1'b1, 1'b0);
    wr(8'hE0, 4'hB, 32'hFFFF_FFFF);
    rd(8'hE0, rdat);
    `CHK(rdat, 32'h0020_0000)
    exp_flags = 16'h0000;
    repeat (3)
    begin
      sthr = 16'($urandom_range(16'hFFFE));
      dthr = 16'($urandom_range(16'hFFFE));
      for (int i = 0; i < 16; i++)
      begin
        for (int j = 0; j < 16; j++)
          err_count[j] = j[2] ? dthr : sthr;
        err_count[i] = (i[2] ? dthr : sthr) + 16'h1;
        exp_flags = exp_flags | hits();
        @(negedge clk);
        `CHK(flags_out, exp_flags)
      end
      err_count = '0;
      @(negedge clk);
      `CHK(flags_out, exp_flags)
      wr(8'hDC, 4'h3, 32'h0);
      `CHK(flags_out, exp_flags)
      m = 16'($urandom);
      wr(8'hDC, 4'h3, {16'h0, m});
      exp_flags = exp_flags & ~m;
      rd(8'hDC, rdat);
      `CHK(rdat, {16'h0, exp_flags})
    end
    // Corner: a clear that meets a live hit loses, then works once the count drops
    err_count[0] = sthr + 16'h1;
    wr(8'hDC, 4'h1, 32'h0000_0001);
    `CHK(flags_out[0], 1'b1)
    err_count = '0;
    wr(8'hDC, 4'h1, 32'h0000_0001);
    exp_flags = exp_flags & 16'hFFFE;
    `CHK(flags_out, exp_flags)
    wr(8'hDC, 4'h1, 32'hFFFF_FFFF);
    exp_flags = exp_flags & 16'hFF00;
    `CHK(flags_out, exp_flags)
    rd(8'hE4, rdat);
    `CHK(rdat, 32'h0)
    warm_rst = 1'b1;
    @(negedge clk);
    warm_rst = 1'b0;
    @(negedge clk);
    `CHK(flags_out, exp_flags)
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    `CHK(flags_out, 16'h0000)
    wrap_up();
  end

  // Cut a hang well past the hundred or so cycles the sequence needs
  initial
  begin
    #75000;
    n_mismatch++;
    wrap_up();
  end
endmodule

`default_nettype wire
